// [verilog/adcc_top.sv]
// adcc_top: apb register slave and control of an 8-bit sar converter
// assumes the analog core drives compHigh asynchronously and follows dacCode
//
// Summary of operation
// - the done flag in bit 7 of the control register is set at completion, cleared by reading the result or writing the control register.
// - while the done flag reads 1 the result register holds a completed conversion.
// - control bit 4 always reads 0.
// - control bit 5 powers the converter on when 1 and off when 0, under software control only.
// - control bits 2 to 0 pick analog input 0 to 7 in plain binary.
// - the number of implemented inputs is a parameter that bounds the valid channel codes.
// - the result register is read-only, 8 bits, holding the latest conversion.
// - reset clears the control and result registers.
// - a powered converter converts the selected channel back to back.
// - a control register write aborts the running conversion, clears the flag and starts anew if it writes bit 5 as 1.
// - a conversion takes 64 clocks, the first 31.5 of them sampling; the code rounds sampling up to 32.
// - completion raises no interrupt; software polls the flag.
//
// The APB register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "adcc_cfg.svh"

module adcc_top #(
   parameter int NUM_INPUTS = 8,
   parameter int STAB_CYC   = `ADCC_STAB_CYC
) (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   input  wire logic        compHigh,
   output var  logic        convPowerOn,
   output var  logic [2:0]  convChannel,
   output var  logic        convSample,
   output var  logic [7:0]  dacCode,
   output var  logic        irq
);

   logic                 compMeta_r;
   logic                 compSync_r;
   logic                 pready_r;
   logic                 pslverr_r;
   logic [31:0]          prdata_r;
   adcc_pkg::adcc_byte_t rdSnap_r;
   adcc_pkg::adcc_byte_t rdByte;
   logic                 done_r;
   logic                 pwr_r;
   logic [2:0]           ch_r;
   adcc_pkg::adcc_byte_t result_r;
   adcc_pkg::adcc_byte_t irqStat_r;
   adcc_pkg::adcc_byte_t irqStat_nxt;
   adcc_pkg::adcc_byte_t irqMask_r;
   adcc_pkg::adcc_byte_t events;
   logic                 irq_r;
   logic [15:0]          stabCnt_r;
   logic                 settled_r;
   logic                 seqDone;
   logic                 seqSample;
   adcc_pkg::adcc_byte_t seqDac;
   adcc_pkg::adcc_byte_t seqResult;
   logic                 setupPh;
   logic                 accessPh;
   logic                 hitRes;
   logic                 hitCsr;
   logic                 hitStat;
   logic                 hitMask;
   logic                 mapped;
   logic                 csrWrite;
   logic                 maskWrite;
   logic                 resRead;
   logic                 statRead;
   logic                 convDone;
   logic                 settleEvt;
   logic                 doneSnap_r;
   logic                 seqEnable;
   logic [5:0]           gapCnt_r;
   logic                 gapOk_r;

   localparam logic [15:0] STAB_LAST = 16'(STAB_CYC - 1);
   localparam logic [5:0]  GAP_LAST  = 6'(`ADCC_CONV_CYC - 2);

   function automatic logic hitReg(input logic [11:0] a, input logic [7:0] idx);
      return a == {2'b00, idx, 2'b00};
   endfunction

   function automatic logic chanOk(input logic [2:0] c);
      return 32'(c) < NUM_INPUTS;
   endfunction

   // comparator comes from the analog side, so two flops before use
   always_ff @(posedge core_clk) begin
      if (rst) begin
         compMeta_r <= 1'b0;
         compSync_r <= 1'b0;
      end else begin
         compMeta_r <= compHigh;
         compSync_r <= compMeta_r;
      end
   end

   assign setupPh   = psel && !penable;
   assign accessPh  = psel && penable && pready_r;
   assign hitRes    = hitReg(paddr, `ADCC_IDX_RESULT);
   assign hitCsr    = hitReg(paddr, `ADCC_IDX_CSR);
   assign hitStat   = hitReg(paddr, `ADCC_IDX_IRQ_STAT);
   assign hitMask   = hitReg(paddr, `ADCC_IDX_IRQ_MASK);
   assign mapped    = hitRes || hitCsr || hitStat || hitMask;
   assign csrWrite  = accessPh && pwrite && hitCsr;
   assign maskWrite = accessPh && pwrite && hitMask;
   assign resRead   = accessPh && !pwrite && hitRes;
   assign statRead  = accessPh && !pwrite && hitStat;

   always_comb begin
      rdByte = 8'h00;
      if (hitRes) begin
         rdByte = result_r;
      end else if (hitCsr) begin
         rdByte[`ADCC_CSR_DONE_BIT] = done_r;
         rdByte[`ADCC_CSR_PWR_BIT]  = pwr_r;
         rdByte[`ADCC_CSR_ZERO_BIT] = 1'b0;
         rdByte[`ADCC_CSR_CH_MSB:`ADCC_CSR_CH_LSB] = ch_r;
      end else if (hitStat) begin
         rdByte = irqStat_r;
      end else if (hitMask) begin
         rdByte = irqMask_r;
      end
   end

   // answer always one access cycle; read data frozen at setup
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
         rdSnap_r  <= 8'h00;
         doneSnap_r <= 1'b0;
      end else begin
         pready_r <= setupPh;
         if (setupPh) begin
            pslverr_r <= !mapped;
            prdata_r  <= {24'h00_0000, rdByte};
            rdSnap_r  <= rdByte;
            doneSnap_r <= done_r;
         end else if (accessPh) begin
            pslverr_r <= 1'b0;
         end
      end
   end

   // reserved bits are not stored; writes there are dropped
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pwr_r <= 1'(`ADCC_CSR_RST >> `ADCC_CSR_PWR_BIT);
         ch_r  <= 3'h0;
      end else if (csrWrite) begin
         pwr_r <= pwdata[`ADCC_CSR_PWR_BIT];
         if (chanOk(pwdata[`ADCC_CSR_CH_MSB:`ADCC_CSR_CH_LSB])) begin
            ch_r <= pwdata[`ADCC_CSR_CH_MSB:`ADCC_CSR_CH_LSB];
         end
      end
   end

   // written power bit reaches the sequencer at once, so sampling starts next cycle
   assign seqEnable = csrWrite ? pwdata[`ADCC_CSR_PWR_BIT] : pwr_r;

   adcc_sar_seq u_seq (
      .core_clk   (core_clk),
      .rst        (rst),
      .enable     (seqEnable),
      .restart    (csrWrite),
      .compHigh   (compSync_r),
      .sampling_r (seqSample),
      .dac_r      (seqDac),
      .res_r      (seqResult),
      .done_r     (seqDone)
   );

   // an aborting write in the completion cycle wins: that result is discarded
   assign convDone = seqDone && !csrWrite;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         done_r <= 1'b0;
      end else if (csrWrite) begin
         done_r <= 1'b0;
      end else if (convDone) begin
         done_r <= 1'b1;
      end else if (resRead && doneSnap_r) begin
         done_r <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         result_r <= `ADCC_RESULT_RST;
      end else if (convDone) begin
         result_r <= seqResult;
      end
   end

   // stabilisation is only reported; conversions run meanwhile
   always_ff @(posedge core_clk) begin
      if (rst || !pwr_r) begin
         stabCnt_r <= 16'h0000;
         settled_r <= 1'b0;
      end else if (!settled_r) begin
         stabCnt_r <= stabCnt_r + 16'h0001;
         settled_r <= stabCnt_r == STAB_LAST;
      end
   end

   assign settleEvt = pwr_r && !settled_r && stabCnt_r == STAB_LAST;

   // completion itself is never an interrupt source, only overrun and settling
   always_comb begin
      events = 8'h00;
      events[`ADCC_IRQ_OVR_BIT]    = convDone && done_r;
      events[`ADCC_IRQ_SETTLE_BIT] = settleEvt;
      irqStat_nxt = irqStat_r;
      if (statRead) begin
         irqStat_nxt = irqStat_r & ~rdSnap_r;
      end
      irqStat_nxt = irqStat_nxt | events;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         irqStat_r <= `ADCC_IRQ_RST;
         irqMask_r <= `ADCC_IRQ_RST;
         irq_r     <= 1'b0;
      end else begin
         irqStat_r <= irqStat_nxt;
         if (maskWrite) begin
            irqMask_r <= pwdata[7:0];
         end
         irq_r <= |(irqStat_nxt & (maskWrite ? pwdata[7:0] : irqMask_r));
      end
   end

   assign prdata      = prdata_r;
   assign pready      = pready_r;
   assign pslverr     = pslverr_r;
   assign convPowerOn = pwr_r;
   assign convChannel = ch_r;
   assign convSample  = seqSample;
   assign dacCode     = seqDac;
   assign irq         = irq_r;

   // cycles since the last completion; a control register write or power off spoils the count
   always_ff @(posedge core_clk) begin
      if (rst || csrWrite || !pwr_r) begin
         gapCnt_r <= 6'h00;
         gapOk_r  <= 1'b0;
      end else if (seqDone) begin
         gapCnt_r <= 6'h00;
         gapOk_r  <= 1'b1;
      end else if (gapCnt_r != 6'h3F) begin
         gapCnt_r <= gapCnt_r + 6'h01;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   a_result_with_flag: assert property (convDone |=> done_r
      && result_r == $past(seqResult))
      else $error("flag set without matching result");
   a_write_clears: assert property (csrWrite |=> !done_r ##1 !done_r)
      else $error("control write left flag set");
   a_read_clears: assert property (resRead && doneSnap_r && !convDone |=> !done_r)
      else $error("result read did not clear flag");
   a_flag_holds: assert property (done_r && !csrWrite && !resRead |=> done_r)
      else $error("flag dropped without a clearing access");
   a_bit4_zero: assert property (pready_r && hitCsr |-> !prdata_r[4])
      else $error("bit 4 read as one");
   a_power_write: assert property (csrWrite |=> convPowerOn == $past(pwdata[5]))
      else $error("power bit not taken from write");
   a_chan_valid: assert property (32'(convChannel) < NUM_INPUTS)
      else $error("channel beyond implemented inputs");
   a_reset_clear: assert property ($past(rst) |-> !done_r && result_r == 8'h00
      && !convPowerOn && convChannel == 3'h0)
      else $error("registers not cleared by reset");
   a_write_restart: assert property (csrWrite && pwdata[5] |=> convSample [*8])
      else $error("control write did not restart sampling");
   a_no_done_irq: assert property (convDone && !done_r && !settleEvt
      && irqStat_r == 8'h00 |=> irqStat_r == 8'h00)
      else $error("completion raised an interrupt");
   a_conv_period: assert property (gapOk_r && gapCnt_r == GAP_LAST && !csrWrite
      && pwr_r |=> seqDone)
      else $error("conversion period is not 64 cycles");

   c_poll_read: cover property (done_r ##[1:200] resRead);
   c_overrun: cover property (irqStat_r[`ADCC_IRQ_OVR_BIT] && irq_r);
   c_abort: cover property (csrWrite && convSample == 1'b0 && pwr_r);
   c_settled: cover property (settleEvt);

endmodule // adcc_top
`default_nettype wire

// [verilog/adcc_cfg.svh]
// adcc_cfg.svh: register indices, field positions, reset values and timing counts
// assumes a 25 MHz core clock and 32-bit apb data with one word per register
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH

// register indices; byte address is four times the index
`define ADCC_IDX_RESULT      8'h70
`define ADCC_IDX_CSR         8'h71
`define ADCC_IDX_IRQ_STAT    8'h72
`define ADCC_IDX_IRQ_MASK    8'h73

// control/status fields
`define ADCC_CSR_DONE_BIT    7
`define ADCC_CSR_RSVD6_BIT   6
`define ADCC_CSR_PWR_BIT     5
`define ADCC_CSR_ZERO_BIT    4
`define ADCC_CSR_RSVD3_BIT   3
`define ADCC_CSR_CH_MSB      2
`define ADCC_CSR_CH_LSB      0

// interrupt status/mask fields
`define ADCC_IRQ_OVR_BIT     0
`define ADCC_IRQ_SETTLE_BIT  1

// reset values
`define ADCC_RESULT_RST      8'h00
`define ADCC_CSR_RST         8'h00
`define ADCC_IRQ_RST         8'h00

// timing
`define ADCC_CLK_PERIOD_NS   40
`define ADCC_CONV_CYC        64
`define ADCC_SAMPLE_CYC      32
`define ADCC_BIT_CYC         4
`define ADCC_STAB_TIME_US    30
`define ADCC_STAB_CYC        ((`ADCC_STAB_TIME_US * 1000) / `ADCC_CLK_PERIOD_NS)

`endif

// [verilog/adcc_pkg.sv]
// adcc_pkg: types shared by the converter control files
// assumes nothing beyond a systemverilog compiler
package adcc_pkg;

   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_SAMPLE,
      SEQ_TRIAL
   } adcc_seq_state_t;

   typedef logic [7:0] adcc_byte_t;

endpackage

// [verilog/adcc_sar_seq.sv]
// adcc_sar_seq: sampling and successive-approximation sequencer
// assumes a synchronised comparator level, high when the input is at or above dacCode
`timescale 1ns/100ps
`default_nettype none
`include "adcc_cfg.svh"

module adcc_sar_seq (
   input  wire logic              core_clk,
   input  wire logic              rst,
   input  wire logic              enable,
   input  wire logic              restart,
   input  wire logic              compHigh,
   output var  logic              sampling_r,
   output var  adcc_pkg::adcc_byte_t dac_r,
   output var  adcc_pkg::adcc_byte_t res_r,
   output var  logic              done_r
);

   adcc_pkg::adcc_seq_state_t state_r;
   logic [5:0]                cnt_r;
   logic [2:0]                bitIdx;

   localparam logic [5:0] SAMPLE_LAST = 6'(`ADCC_SAMPLE_CYC - 1);
   localparam logic [5:0] CONV_LAST   = 6'(`ADCC_CONV_CYC - 1);
   localparam logic [1:0] BIT_LAST    = 2'(`ADCC_BIT_CYC - 1);

   // four cycles per bit after a 32-cycle sample, msb first
   function automatic logic [2:0] trialBit(input logic [5:0] c);
      return 3'h7 - c[4:2];
   endfunction

   assign bitIdx = trialBit(cnt_r);

   always_ff @(posedge core_clk) begin
      if (rst || !enable) begin
         state_r <= adcc_pkg::SEQ_IDLE;
         cnt_r   <= 6'h00;
      end else if (restart || state_r == adcc_pkg::SEQ_IDLE) begin
         state_r <= adcc_pkg::SEQ_SAMPLE;
         cnt_r   <= 6'h00;
      end else begin
         cnt_r <= cnt_r + 6'h01;
         unique case (state_r)
            adcc_pkg::SEQ_SAMPLE: if (cnt_r == SAMPLE_LAST) state_r <= adcc_pkg::SEQ_TRIAL;
            adcc_pkg::SEQ_TRIAL:  if (cnt_r == CONV_LAST) state_r <= adcc_pkg::SEQ_SAMPLE;
            adcc_pkg::SEQ_IDLE:   state_r <= adcc_pkg::SEQ_SAMPLE;
         endcase
      end
   end

   // sample phase rounded up to whole cycles
   always_ff @(posedge core_clk) begin
      if (rst || !enable) begin
         sampling_r <= 1'b0;
      end else begin
         sampling_r <= restart || state_r == adcc_pkg::SEQ_IDLE
                       || (state_r == adcc_pkg::SEQ_SAMPLE && cnt_r != SAMPLE_LAST)
                       || (state_r == adcc_pkg::SEQ_TRIAL && cnt_r == CONV_LAST);
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst || !enable || restart) begin
         dac_r  <= 8'h00;
         done_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (state_r == adcc_pkg::SEQ_SAMPLE && cnt_r == SAMPLE_LAST) begin
            dac_r <= 8'h80;
         end else if (state_r == adcc_pkg::SEQ_TRIAL && cnt_r[1:0] == BIT_LAST) begin
            if (bitIdx != 3'h0) begin
               dac_r[bitIdx]        <= compHigh;
               dac_r[bitIdx - 3'h1] <= 1'b1;
            end else begin
               dac_r  <= 8'h00;
               done_r <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         res_r <= `ADCC_RESULT_RST;
      end else if (enable && !restart && state_r == adcc_pkg::SEQ_TRIAL
                   && cnt_r == CONV_LAST) begin
         res_r <= {dac_r[7:1], compHigh};
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   a_done_at_end: assert property (done_r |-> $past(cnt_r) == 6'h3F
      && $past(state_r) == adcc_pkg::SEQ_TRIAL)
      else $error("conversion ended off the 64th cycle");
   a_conv_continues: assert property (done_r && enable && !restart
      |-> state_r == adcc_pkg::SEQ_SAMPLE && sampling_r)
      else $error("no new conversion after completion");
   a_sample_width: assert property ($rose(sampling_r) && enable
      |-> sampling_r [*8])
      else $error("sampling phase cut short");
   c_two_conv: cover property (done_r ##64 done_r);

endmodule // adcc_sar_seq
`default_nettype wire

// [testbench/adcc_analog_model.sv]
// adcc_analog_model: behavioural analog core and input multiplexer
// assumes the control block follows dacCode with a synchronised compHigh
`timescale 1ns/100ps
`default_nettype none

module adcc_analog_model (
   input  wire logic        core_clk,
   input  wire logic        convPowerOn,
   input  wire logic [2:0]  convChannel,
   input  wire logic        convSample,
   input  wire logic [7:0]  dacCode,
   input  wire logic [63:0] levelBus,
   output var  logic        compHigh
);
   logic [7:0] heldLevel = 8'h00;
   logic       toggle    = 1'b0;

   // track-and-hold: last value seen while sampling is the one converted
   always @(posedge core_clk) begin
      if (convSample) begin
         heldLevel <= levelBus[{convChannel, 3'b000} +: 8];
      end
      toggle <= ~toggle;
   end

   // unpowered comparator gives no usable level, so it wanders
   always @(posedge core_clk) begin
      compHigh <= convPowerOn ? (heldLevel >= dacCode) : toggle;
   end
endmodule // adcc_analog_model

`default_nettype wire

// [testbench/adc_control_status_logic_bench.sv]
// adc_control_status_logic_bench: self-checking bench for adcc_top
// assumes adcc_analog_model on the converter side, apb master driven here
`timescale 1ns/100ps
`default_nettype none

module adc_control_status_logic_bench;
   typedef struct {logic [7:0] wr; logic [7:0] adc_control_status; logic [7:0] res;} adcc_row_t;
   logic        core_clk = 1'b0;
   logic        rst      = 1'b1;
   logic        psel     = 1'b0;
   logic        penable  = 1'b0;
   logic        pwrite   = 1'b0;
   logic [11:0] paddr    = 12'h000;
   logic [31:0] pwdata   = 32'h00000000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        compHigh;
   logic        convPowerOn;
   logic [2:0]  convChannel;
   logic        convSample;
   logic [7:0]  dacCode;
   logic        irq;
   logic [63:0] levelBus = 64'hC35AFF01807FA500;
   logic [7:0]  rdv;
   logic        errv;
   int          cyc = 0;
   int          tv;
   int          t0;
   int          miscompares = 0;
   int          testsRun = 0;
   // codes 6 and 7 exceed the six inputs built here and are refused
   adcc_row_t   rows [7] = '{'{8'h20, 8'hA0, 8'h00}, '{8'h31, 8'hA1, 8'hA5},
      '{8'h22, 8'hA2, 8'h7F}, '{8'h23, 8'hA3, 8'h80}, '{8'h34, 8'hA4, 8'h01},
      '{8'h25, 8'hA5, 8'hFF}, '{8'h26, 8'hA5, 8'hFF}};

   always #20 core_clk = ~core_clk;
   always @(posedge core_clk) cyc <= cyc + 1;

   adcc_top #(.NUM_INPUTS(6), .STAB_CYC(20)) adcc_top_inst (
      .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .compHigh(compHigh), .convPowerOn(convPowerOn), .convChannel(convChannel),
      .convSample(convSample), .dacCode(dacCode), .irq(irq));

   adcc_analog_model adcc_analog_model_inst (
      .core_clk(core_clk), .convPowerOn(convPowerOn), .convChannel(convChannel),
      .convSample(convSample), .dacCode(dacCode), .levelBus(levelBus), .compHigh(compHigh));

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      testsRun++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // one apb transfer; pready, data and error taken at the rising edge that ends it
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge core_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {2'b00, idx, 2'b00};
      pwdata  <= {24'h000000, wd};
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) chk("pready", pready, 32'h1);
      rdv  = prdata[7:0];
      errv = pslverr;
      tv   = cyc;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // polling only: no interrupt exists for completion
   task automatic wait_done();
      int k;
      k = 0;
      do begin
         apb(1'b0, 8'h71, 8'h00);
         k++;
      end while (rdv[7] !== 1'b1 && k < 60);
      if (k == 60) chk("done flag", rdv[7], 32'h1);
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", testsRun, miscompares);
      if (miscompares == 0 && testsRun > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      #(40 * 20000);
      chk("watchdog", 32'h1, 32'h0);
      give_verdict();
   end

   initial begin
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      for (int i = 0; i < 7; i++) begin
         apb(1'b1, 8'h71, rows[i].wr);
         t0 = tv;
         wait_done();
         chk("csr", rdv, rows[i].adc_control_status);
         // 64 cycles, flag register, setup and access, then up to 2 of poll phase
         chk("latency", (tv - t0 >= 67 && tv - t0 <= 69), 32'h1);
         chk("channel", convChannel, rows[i].adc_control_status[2:0]);
         apb(1'b0, 8'h70, 8'h00);
         chk("result", rdv, rows[i].res);
         apb(1'b0, 8'h71, 8'h00);
         chk("flag clear", rdv, rows[i].adc_control_status & 8'h7F);
         $display("row %0d done", i);
      end
      levelBus[47:40] <= 8'h3C;
      wait_done();
      apb(1'b0, 8'h70, 8'h00);
      wait_done();
      apb(1'b0, 8'h70, 8'h00);
      chk("continuous", rdv, 32'h3C);
      $display("continuous done");
      apb(1'b1, 8'h71, 8'h20);
      repeat (40) @(posedge core_clk);
      apb(1'b1, 8'h71, 8'h21);
      t0 = tv;
      wait_done();
      chk("abort latency", tv - t0 >= 64, 32'h1);
      apb(1'b1, 8'h70, 8'h55);
      chk("ro error", errv, 32'h0);
      apb(1'b0, 8'h70, 8'h00);
      chk("ro result", rdv, 32'hA5);
      apb(1'b0, 8'h74, 8'h00);
      chk("unmapped", {errv, rdv}, 32'h100);
      $display("abort and access done");
      apb(1'b1, 8'h71, 8'h00);
      @(negedge core_clk);
      chk("power off", convPowerOn, 32'h0);
      repeat (100) @(posedge core_clk);
      apb(1'b0, 8'h71, 8'h00);
      chk("off csr", rdv, 32'h00);
      apb(1'b1, 8'h73, 8'h03);
      apb(1'b0, 8'h72, 8'h00);
      apb(1'b1, 8'h71, 8'h20);
      repeat (30) @(posedge core_clk);
      chk("settle irq", irq, 32'h1);
      apb(1'b0, 8'h72, 8'h00);
      chk("settle stat", rdv, 32'h02);
      repeat (2) @(negedge core_clk);
      chk("irq cleared", irq, 32'h0);
      wait_done();
      chk("no done irq", irq, 32'h0);
      repeat (70) @(posedge core_clk);
      @(negedge core_clk);
      chk("overrun irq", irq, 32'h1);
      apb(1'b0, 8'h72, 8'h00);
      chk("overrun stat", rdv[0], 32'h1);
      apb(1'b1, 8'h73, 8'h00);
      apb(1'b1, 8'h71, 8'h00);
      apb(1'b0, 8'h72, 8'h00);
      apb(1'b1, 8'h71, 8'h21);
      repeat (30) @(posedge core_clk);
      chk("masked irq", irq, 32'h0);
      apb(1'b0, 8'h72, 8'h00);
      chk("masked stat", rdv, 32'h02);
      $display("interrupt done");
      wait_done();
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      apb(1'b0, 8'h70, 8'h00);
      chk("rst result", rdv, 32'h00);
      apb(1'b0, 8'h71, 8'h00);
      chk("rst csr", {convPowerOn, rdv}, 32'h000);
      $display("reset done");
      give_verdict();
   end
endmodule // adc_control_status_logic_bench

`default_nettype wire
